/* src/dsr_defines.svh */
// Offsets, field positions and reset values for the device status register block
`ifndef DSR_DEFINES_SVH
`define DSR_DEFINES_SVH

// Register byte offsets
`define DSR_ADDR_DEV_CTRL 20'h0_0000
`define DSR_ADDR_DEV_STATUS 20'h0_0008
`define DSR_ADDR_EXT_CTRL 20'h0_0018
`define DSR_ADDR_VARIANT 20'h0_0030
`define DSR_ADDR_IRQ_STATUS 20'h0_0040
`define DSR_ADDR_IRQ_CLEAR 20'h0_0044
`define DSR_ADDR_IRQ_ENABLE 20'h0_0048

// device_control fields
`define DSR_CTRL_SW_DUPLEX_BIT 0
`define DSR_CTRL_FORCE_LINK_BIT 1
`define DSR_CTRL_AUTONEG_BIT 2
`define DSR_CTRL_FLOW_EN_BIT 3
`define DSR_CTRL_MASK 32'h0000_000f

// extended_control_word fields
`define DSR_EXT_LINK_SEL_LSB 0
`define DSR_EXT_MASK 32'h0000_0003
`define DSR_LINK_SEL_PHY 2'h0

// Variant select register
`define DSR_VARIANT_MASK 32'h0000_0003

// device_status fields
`define DSR_ST_DUPLEX_BIT 0
`define DSR_ST_LINK_BIT 1
`define DSR_ST_PORT_LSB 2
`define DSR_ST_PAUSED_BIT 4
`define DSR_ST_SERDES_BIT 5

// Interrupt status, clear and enable layout
`define DSR_IRQ_LINK_CHG_BIT 0
`define DSR_IRQ_DUPLEX_CHG_BIT 1
`define DSR_IRQ_PAUSE_ON_BIT 2
`define DSR_IRQ_PAUSE_OFF_BIT 3
`define DSR_IRQ_MASK 32'h0000_000f

// Reset values
`define DSR_DEV_CTRL_RESET 32'h0000_0000
`define DSR_EXT_CTRL_RESET 32'h0000_0000
`define DSR_VARIANT_RESET 2'h0
`define DSR_IRQ_ENABLE_RESET 4'h0
`define DSR_PORT_ID_RESET 2'h0

// Bus responses
`define DSR_RESP_OKAY 2'h0
`define DSR_RESP_SLVERR 2'h2

`endif

/* src/dsr_pause.sv */
// Transmit pause tracker driven by received XOFF and XON frames
`timescale 1ns/1ps
`include "dsr_defines.svh"

module dsr_pause import dsr_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire dsr_pause_in_t pin,
    input wire logic enable,
    output logic paused
);

    dsr_pause_reg_t st;
    dsr_pause_reg_t next_st;

    always_comb begin
        next_st = st;
        case (st.state)
            DSR_PS_RUN: begin
                // A zero-quanta XOFF asks for no pause at all
                if (enable && pin.xoff && pin.quanta != 16'h0000) begin
                    next_st.state = DSR_PS_PAUSED; // [R9]
                    next_st.timer = pin.quanta;
                end
            end
            DSR_PS_PAUSED: begin
                if (!enable) begin
                    next_st.state = DSR_PS_RUN; // [R11]
                end else if (pin.xon) begin
                    next_st.state = DSR_PS_RUN; // [R10]
                end else if (pin.xoff) begin
                    // A fresh XOFF restarts the timer, zero quanta ends pause
                    if (pin.quanta == 16'h0000) begin
                        next_st.state = DSR_PS_RUN;
                    end else begin
                        next_st.timer = pin.quanta;
                    end
                end else if (pin.tick) begin
                    if (st.timer <= 16'h0001) begin
                        next_st.state = DSR_PS_RUN; // [R10]
                        next_st.timer = 16'h0000;
                    end else begin
                        next_st.timer = st.timer - 16'h0001;
                    end
                end
            end
            default: begin
                next_st.state = DSR_PS_RUN;
            end
        endcase
        next_st.paused = (next_st.state == DSR_PS_PAUSED);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.state <= DSR_PS_RUN;
        end else begin
            st <= next_st;
        end
    end

    assign paused = st.paused;

endmodule : dsr_pause

/* src/dsr_pkg.sv */
// Types shared by the device status register block
package dsr_pkg;

    typedef enum logic [1:0] {
        DSR_VAR_A,
        DSR_VAR_B,
        DSR_VAR_C
    } dsr_variant_t;

    typedef struct packed {
        logic an_duplex_full;
        logic an_link_ok;
        logic phy_link;
    } dsr_link_in_t;

    typedef struct packed {
        logic xoff;
        logic xon;
        logic tick;
        logic [15:0] quanta;
    } dsr_pause_in_t;

    typedef enum logic {
        DSR_PS_RUN,
        DSR_PS_PAUSED
    } dsr_pause_state_t;

    typedef struct packed {
        dsr_pause_state_t state;
        logic [15:0] timer;
        logic paused;
    } dsr_pause_reg_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic aw_have;
        logic [19:0] aw_addr;
        logic w_have;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic [31:0] dev_ctrl;
        logic [31:0] ext_ctrl;
        logic [1:0] variant;
        logic [3:0] irq_status;
        logic [3:0] irq_enable;
        logic irq;
        logic duplex;
        logic link;
        logic [1:0] port_id;
        logic port_loaded;
        logic serdes_bit;
        logic paused_d;
    } dsr_top_reg_t;

endpackage : dsr_pkg

/* src/dsr_top.sv */
// Device status register bank with AXI4-Lite access and status interrupt
// Functional notes
// [R1] Bit 0: zero half, one full duplex
// [R2] Duplex follows auto-negotiation or software setting
// [R3] Bit 1 reports link configured state
// [R4] Some variants: link valid only when forced
// [R5] SerDes with autoneg: link after valid negotiation
// [R6] SerDes forced: link mirrors force control
// [R7] Internal PHY: link tracks internal link signal
// [R8] Bits 3:2 give port identifier, reset zero
// [R9] Bit 4 sets on XOFF with flow control
// [R10] Pause clears on timer expiry or XON
// [R11] Pause flag only in full-duplex flow mode
// [R12] Variant A: bit 5 from link select
// [R13] Variant B: bit 5 SerDes one, PHY zero
// [R14] Variant C: bit 5 reserved
// [R15] Status reads and writes have no effect
`timescale 1ns/1ps
`include "dsr_defines.svh"

module dsr_top import dsr_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [19:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [19:0] araddr,
    input wire logic [2:0] arprot,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    input wire dsr_link_in_t link_in,
    input wire dsr_pause_in_t pause_in,
    input wire logic [1:0] port_strap,
    output logic tx_paused,
    output logic irq
);

    dsr_top_reg_t st;
    dsr_top_reg_t next_st;

    logic aw_fire;
    logic w_fire;
    logic [19:0] wr_addr;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic [31:0] wmask;
    logic pause_enable;
    logic paused;
    logic serdes_mode;
    logic raw_link;

    assign aw_fire = awvalid & st.awready;
    assign w_fire = wvalid & st.wready;

    // Address and data may arrive in either order; use the held copy if taken earlier
    assign wr_addr = st.aw_have ? st.aw_addr : awaddr;
    assign wr_data = st.w_have ? st.w_data : wdata;
    assign wr_strb = st.w_have ? st.w_strb : wstrb;

    generate
        for (genvar b = 0; b < 4; b++) begin : g_lane
            assign wmask[8*b +: 8] = {8{wr_strb[b]}};
        end
    endgenerate

    // Pause reporting is only meaningful in full duplex with flow control on
    assign pause_enable = st.duplex & st.dev_ctrl[`DSR_CTRL_FLOW_EN_BIT]; // [R11]

    dsr_pause u_pause (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(pause_in),
        .enable(pause_enable),
        .paused(paused)
    );

    assign serdes_mode = (st.ext_ctrl[`DSR_EXT_LINK_SEL_LSB +: 2] != `DSR_LINK_SEL_PHY);

    // Link source before any variant gating
    always_comb begin
        if (!serdes_mode) begin
            raw_link = link_in.phy_link; // [R7]
        end else if (st.dev_ctrl[`DSR_CTRL_AUTONEG_BIT]) begin
            raw_link = link_in.an_link_ok; // [R5]
        end else begin
            raw_link = st.dev_ctrl[`DSR_CTRL_FORCE_LINK_BIT]; // [R6]
        end
    end

    function automatic logic [31:0] status_word(input dsr_top_reg_t s, input logic p);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`DSR_ST_DUPLEX_BIT] = s.duplex; // [R1]
        w[`DSR_ST_LINK_BIT] = s.link; // [R3]
        w[`DSR_ST_PORT_LSB +: 2] = s.port_id; // [R8]
        w[`DSR_ST_PAUSED_BIT] = p; // [R9]
        w[`DSR_ST_SERDES_BIT] = s.serdes_bit;
        return w;
    endfunction : status_word

    function automatic logic [32:0] read_word(input dsr_top_reg_t s, input logic p, input logic [19:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h0000_0000};
        case (a)
            `DSR_ADDR_DEV_CTRL: r = {1'b1, s.dev_ctrl};
            `DSR_ADDR_DEV_STATUS: r = {1'b1, status_word(s, p)};
            `DSR_ADDR_EXT_CTRL: r = {1'b1, s.ext_ctrl};
            `DSR_ADDR_VARIANT: r = {1'b1, 30'h0000_0000, s.variant};
            `DSR_ADDR_IRQ_STATUS: r = {1'b1, 28'h000_0000, s.irq_status};
            // The clear register is write-only and reads back as zero
            `DSR_ADDR_IRQ_CLEAR: r = {1'b1, 32'h0000_0000};
            `DSR_ADDR_IRQ_ENABLE: r = {1'b1, 28'h000_0000, s.irq_enable};
            default: r = {1'b0, 32'h0000_0000};
        endcase
        return r;
    endfunction : read_word

    always_comb begin
        logic wr_go;
        logic [32:0] rd;
        logic [3:0] clr;
        logic [3:0] ev;
        wr_go = 1'b0;
        rd = {1'b0, 32'h0000_0000};
        clr = 4'h0;
        ev = 4'h0;
        next_st = st;

        // Write channel capture
        if (aw_fire) begin
            next_st.aw_have = 1'b1;
            next_st.aw_addr = awaddr;
        end
        if (w_fire) begin
            next_st.w_have = 1'b1;
            next_st.w_data = wdata;
            next_st.w_strb = wstrb;
        end
        if (st.bvalid && bready) begin
            next_st.bvalid = 1'b0;
        end

        wr_go = (st.aw_have | aw_fire) & (st.w_have | w_fire) & ~st.bvalid;
        if (wr_go) begin
            next_st.aw_have = 1'b0;
            next_st.w_have = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = `DSR_RESP_OKAY;
            case (wr_addr)
                `DSR_ADDR_DEV_CTRL: begin
                    next_st.dev_ctrl = ((st.dev_ctrl & ~wmask) | (wr_data & wmask)) & `DSR_CTRL_MASK;
                end
                `DSR_ADDR_EXT_CTRL: begin
                    next_st.ext_ctrl = ((st.ext_ctrl & ~wmask) | (wr_data & wmask)) & `DSR_EXT_MASK;
                end
                `DSR_ADDR_VARIANT: begin
                    if (wr_strb[0]) begin
                        next_st.variant = wr_data[1:0];
                    end
                end
                `DSR_ADDR_IRQ_CLEAR: begin
                    clr = wr_data[3:0] & {4{wr_strb[0]}};
                end
                `DSR_ADDR_IRQ_ENABLE: begin
                    if (wr_strb[0]) begin
                        next_st.irq_enable = wr_data[3:0];
                    end
                end
                // Status words are read-only; the write is accepted and dropped
                `DSR_ADDR_DEV_STATUS, `DSR_ADDR_IRQ_STATUS: begin
                    next_st.bresp = `DSR_RESP_OKAY; // [R15]
                end
                default: begin
                    next_st.bresp = `DSR_RESP_SLVERR;
                end
            endcase
        end
        // Hold both write channels while a response is outstanding
        next_st.awready = ~next_st.aw_have & ~next_st.bvalid;
        next_st.wready = ~next_st.w_have & ~next_st.bvalid;

        // Read channel: data is sampled at the address handshake, never altering state
        if (st.rvalid && rready) begin
            next_st.rvalid = 1'b0;
        end
        if (arvalid && st.arready) begin
            rd = read_word(st, paused, araddr); // [R15]
            next_st.rvalid = 1'b1;
            next_st.rdata = rd[31:0];
            next_st.rresp = rd[32] ? `DSR_RESP_OKAY : `DSR_RESP_SLVERR;
        end
        next_st.arready = ~next_st.rvalid;

        // Duplex from whichever source configured it
        if (st.dev_ctrl[`DSR_CTRL_AUTONEG_BIT]) begin
            next_st.duplex = link_in.an_duplex_full; // [R2]
        end else begin
            next_st.duplex = st.dev_ctrl[`DSR_CTRL_SW_DUPLEX_BIT]; // [R2]
        end

        case (dsr_variant_t'(st.variant))
            DSR_VAR_A: begin
                next_st.link = raw_link & st.dev_ctrl[`DSR_CTRL_FORCE_LINK_BIT]; // [R4]
                next_st.serdes_bit = serdes_mode; // [R12]
            end
            DSR_VAR_B: begin
                next_st.link = raw_link; // [R5]
                next_st.serdes_bit = serdes_mode; // [R13]
            end
            DSR_VAR_C: begin
                next_st.link = raw_link & st.dev_ctrl[`DSR_CTRL_FORCE_LINK_BIT]; // [R4]
                next_st.serdes_bit = 1'b0; // [R14]
            end
            default: begin
                // Unused select code behaves as the reserved-bit variant
                next_st.link = raw_link & st.dev_ctrl[`DSR_CTRL_FORCE_LINK_BIT];
                next_st.serdes_bit = 1'b0;
            end
        endcase

        // Strap is caught once, one cycle after reset release
        if (!st.port_loaded) begin
            next_st.port_id = port_strap; // [R8]
            next_st.port_loaded = 1'b1;
        end

        next_st.paused_d = paused;
        ev[`DSR_IRQ_LINK_CHG_BIT] = next_st.link ^ st.link;
        ev[`DSR_IRQ_DUPLEX_CHG_BIT] = next_st.duplex ^ st.duplex;
        ev[`DSR_IRQ_PAUSE_ON_BIT] = paused & ~st.paused_d;
        ev[`DSR_IRQ_PAUSE_OFF_BIT] = ~paused & st.paused_d;
        // A new event in the clearing cycle survives the clear
        next_st.irq_status = (st.irq_status & ~clr) | ev;
        next_st.irq = |(next_st.irq_status & next_st.irq_enable);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.dev_ctrl <= `DSR_DEV_CTRL_RESET;
            st.ext_ctrl <= `DSR_EXT_CTRL_RESET;
            st.variant <= `DSR_VARIANT_RESET;
            st.irq_enable <= `DSR_IRQ_ENABLE_RESET;
            st.port_id <= `DSR_PORT_ID_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign awready = st.awready;
    assign wready = st.wready;
    assign bvalid = st.bvalid;
    assign bresp = st.bresp;
    assign arready = st.arready;
    assign rvalid = st.rvalid;
    assign rdata = st.rdata;
    assign rresp = st.rresp;
    assign irq = st.irq;
    assign tx_paused = paused;

endmodule : dsr_top

/* tb/dsr_top_chk.sv */
// Assertions on the ports of the device status register block
`timescale 1ns/1ps
module dsr_top_chk import dsr_pkg::*; (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [19:0] awaddr,
    input wire logic awvalid,
    input wire logic awready,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic [1:0] bresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [19:0] araddr,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic rvalid,
    input wire logic rready,
    input wire dsr_pause_in_t pause_in,
    input wire logic tx_paused
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_both;
        awvalid && awready && wvalid && wready;
    endsequence
    sequence s_rd_take;
        arvalid && arready;
    endsequence
    a_write_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bvalid dropped");
    a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
        else $error("read answer changed");
    a_write_answer: assert property (s_wr_both |=> bvalid) else $error("write answer late");
    a_read_answer: assert property (s_rd_take |=> rvalid && !arready) else $error("read answer late");
    a_unmapped_read: assert property (s_rd_take and araddr == 20'h0_0100 |=> rresp == 2'h2 && rdata == '0)
        else $error("unmapped read not refused");
    a_busy_refuse: assert property (bvalid |-> !awready && !wready) else $error("write taken while busy");
    a_pause_cause: assert property ($rose(tx_paused) |-> $past(pause_in.xoff) && $past(pause_in.quanta) != 16'h0)
        else $error("pause without xoff");
    a_pause_xon: assert property (tx_paused && pause_in.xon |=> !tx_paused) else $error("xon ignored");
    a_zero_quanta: assert property (pause_in.xoff && pause_in.quanta == 16'h0 |=> !tx_paused)
        else $error("zero quanta paused");
endmodule : dsr_top_chk

bind dsr_top dsr_top_chk chk (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .pause_in(pause_in), .tx_paused(tx_paused));

/* tb/tb_dsr_top.sv */
// Self-checking bench for the device status register block
`timescale 1ns/1ps
`include "dsr_defines.svh"
module tb_dsr_top import dsr_pkg::*;;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, tx_paused, irq;
    logic [19:0] awaddr, araddr;
    logic [31:0] wdata, rdata, got;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, port_strap;
    dsr_link_in_t link_in;
    dsr_pause_in_t pause_in;
    int num_errors, tests_run, ctl, ext, vsel, paused, port, k;
    logic [19:0] regs [4] = '{20'h0_0000, 20'h0_0018, 20'h0_0030, 20'h0_0048};

    dsr_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .link_in(link_in), .pause_in(pause_in), .port_strap(port_strap), .tx_paused(tx_paused), .irq(irq));

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task finish_test;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    task check(input string n, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, exp, seen);
        end
    endtask : check

    task wr(input logic [19:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
        int i;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (i == 50) begin
            num_errors++;
            finish_test();
        end
        bready <= 1'b0;
        check("bresp", 32'(bresp), 32'(er));
    endtask : wr

    task rd(input logic [19:0] a, input logic [31:0] ed, input string n, input logic [1:0] er = 2'h0);
        int i;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (i == 50) begin
            num_errors++;
            finish_test();
        end
        rready <= 1'b0;
        check(n, rdata, ed);
        check("rresp", 32'(rresp), 32'(er));
    endtask : rd

    // One pause-frame event, held for a single cycle
    task pz(input logic xo, input logic xn, input logic tk, input logic [15:0] q);
        @(posedge aclk);
        pause_in <= '{xo, xn, tk, q};
        @(posedge aclk);
        pause_in <= '0;
        #1;
    endtask : pz

    function automatic logic [31:0] st_exp();
        int dup, raw, lk, sd;
        dup = ctl[2] ? link_in.an_duplex_full : ctl[0];
        raw = (ext == 0) ? link_in.phy_link : (ctl[2] ? link_in.an_link_ok : ctl[1]);
        lk = (vsel == 1) ? raw : raw & ctl[1];
        sd = (vsel <= 1) && (ext != 0);
        return 32'(sd * 32 + paused * 16 + port * 4 + lk * 2 + dup);
    endfunction : st_exp

    initial begin
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        awaddr = '0;
        araddr = '0;
        wdata = '0;
        wstrb = 4'hf;
        link_in = '0;
        pause_in = '0;
        {num_errors, tests_run, ctl, ext, vsel, paused} = '0;
        got = $urandom(13);
        port = $urandom & 1;
        port_strap = 2'(port);
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (k = 0; k < 4; k++) rd(regs[k], '0, "reset value");
        rd(`DSR_ADDR_DEV_STATUS, st_exp(), "port id");
        wr(`DSR_ADDR_DEV_STATUS, 32'hffff_ffff);
        rd(`DSR_ADDR_DEV_STATUS, st_exp(), "status ro");
        wr(20'h0_0100, 32'h0000_0001, 2'h2);
        rd(20'h0_0100, '0, "unmapped", 2'h2);
        // Every variant against every link mode, with random controls and link sources
        for (k = 0; k < 32; k++) begin
            vsel = k & 3;
            ext = (k >> 2) & 3;
            ctl = $urandom & 15;
            link_in <= 3'($urandom);
            wr(`DSR_ADDR_DEV_CTRL, 32'(ctl));
            wr(`DSR_ADDR_EXT_CTRL, 32'(ext));
            wr(`DSR_ADDR_VARIANT, 32'(vsel));
            repeat (2) @(posedge aclk);
            rd(`DSR_ADDR_DEV_STATUS, st_exp(), "status");
        end
        ctl = 9;
        wr(`DSR_ADDR_DEV_CTRL, 32'(ctl));
        repeat (3) @(posedge aclk);
        wr(`DSR_ADDR_IRQ_CLEAR, 32'h0000_000f);
        rd(`DSR_ADDR_IRQ_STATUS, '0, "irq status");
        wr(`DSR_ADDR_IRQ_ENABLE, 32'h0000_0004);
        pz(1'b1, 1'b0, 1'b0, 16'h0003);
        paused = 1;
        check("tx_paused", 32'(tx_paused), 32'(paused));
        rd(`DSR_ADDR_DEV_STATUS, st_exp(), "status paused");
        rd(`DSR_ADDR_IRQ_STATUS, 32'h0000_0004, "irq status");
        check("irq", 32'(irq), 32'(1));
        pz(1'b0, 1'b1, 1'b0, 16'h0000);
        paused = 0;
        check("tx_paused", 32'(tx_paused), 32'(paused));
        rd(`DSR_ADDR_IRQ_STATUS, 32'h0000_000c, "irq status");
        wr(`DSR_ADDR_IRQ_ENABLE, '0);
        repeat (2) @(posedge aclk);
        check("irq masked", 32'(irq), '0);
        wr(`DSR_ADDR_IRQ_ENABLE, 32'h0000_0008);
        repeat (2) @(posedge aclk);
        check("irq", 32'(irq), 32'(1));
        wr(`DSR_ADDR_IRQ_CLEAR, 32'h0000_000f);
        repeat (2) @(posedge aclk);
        check("irq cleared", 32'(irq), '0);
        pz(1'b1, 1'b0, 1'b0, 16'h0002);
        pz(1'b0, 1'b0, 1'b1, 16'h0000);
        check("one tick", 32'(tx_paused), 32'(1));
        pz(1'b0, 1'b0, 1'b1, 16'h0000);
        check("timer out", 32'(tx_paused), '0);
        pz(1'b1, 1'b0, 1'b0, 16'h0000);
        check("zero quanta", 32'(tx_paused), '0);
        pz(1'b1, 1'b0, 1'b0, 16'h0009);
        check("paused", 32'(tx_paused), 32'(1));
        // Dropping full duplex mid-pause must cancel the pause
        wr(`DSR_ADDR_DEV_CTRL, 32'h0000_0008);
        repeat (2) @(posedge aclk);
        check("half duplex", 32'(tx_paused), '0);
        pz(1'b1, 1'b0, 1'b0, 16'h0005);
        check("half duplex xoff", 32'(tx_paused), '0);
        wr(`DSR_ADDR_DEV_CTRL, 32'h0000_0001);
        repeat (2) @(posedge aclk);
        pz(1'b1, 1'b0, 1'b0, 16'h0005);
        check("flow off xoff", 32'(tx_paused), '0);
        finish_test();
    end
endmodule : tb_dsr_top
